// *** hdl/operand_decode_pkg.sv ***
// shared types and constants for the operand decode block
package operand_decode_pkg;
  localparam int unsigned WORD_W = 16;
  localparam logic [3:0] BYTE_IDX_MASK = 4'h7;
  localparam logic [3:0] WORD_IDX_MASK = 4'hF;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] BYTE_MASK = 16'h00FF;
  localparam logic [7:0] TABLE_LAST = 8'hFF;
  localparam int unsigned REG_COUNT = 8;
  localparam logic [2:0] REG_SP = 3'h4;
  localparam logic [2:0] REG_IX = 3'h6;
  localparam logic [2:0] REG_IY = 3'h7;
  localparam logic [1:0] SHORT_LAT = 2'h1;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_BIT,
    OP_SHORT_BRANCH,
    OP_BLOCK,
    OP_XLAT,
    OP_RET_POP,
    OP_FAR_PTR,
    OP_MISC
  } op_class_t;

  typedef enum logic [1:0] {
    bit_test_op,
    bit_set_op,
    bit_clear_op,
    bit_invert_op
  } bit_op_t;

  typedef enum logic [1:0] {
    MISC_NEAR_IND,
    MISC_DIRECT,
    MISC_ESCAPE
  } misc_op_t;

  typedef struct packed {
    logic valid;
    op_class_t cls;
    logic word;
    logic idx_from_count;
    logic [3:0] bit_field;
    bit_op_t bit_op;
    misc_op_t misc;
    logic [15:0] value;
    logic [15:0] imm16;
    logic [15:0] aux16;
    logic [7:0] disp8;
    logic [2:0] reg_sel;
    logic blk_dst;
    logic dir_down;
  } decode_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] result;
    logic write_back;
    logic zero;
    logic [15:0] addr;
    logic [15:0] segment;
    logic seg_load;
    logic [15:0] pc_next;
    logic [15:0] sp_next;
    logic [15:0] index_next;
    logic [2:0] index_reg;
    logic index_load;
    logic [7:0] escape_code;
  } decode_rsp_t;
endpackage : operand_decode_pkg

// *** hdl/bit_manip_unit.sv ***
// single bit test, set, clear and invert on a byte or word operand
`timescale 1ns/1ns
module bit_manip_unit (
  input wire logic [15:0] value_i,
  input wire logic word_i,
  input wire logic [3:0] index_i,
  input wire operand_decode_pkg::bit_op_t op_i,
  output logic [15:0] result_o,
  output logic zero_o
);
  logic [15:0] sel;
  logic [15:0] keep;

  always_comb
  begin
    sel = 16'h0001 << index_i;
    keep = word_i ? 16'hFFFF : operand_decode_pkg::BYTE_MASK;
    zero_o = (value_i & sel) == 16'h0000; // RQ2
    case (op_i)
      operand_decode_pkg::bit_set_op: result_o = (value_i | sel) & keep; // RQ2
      operand_decode_pkg::bit_clear_op: result_o = value_i & ~sel & keep;
      operand_decode_pkg::bit_invert_op: result_o = (value_i ^ sel) & keep;
      default: result_o = value_i & keep;
    endcase
  end
endmodule : bit_manip_unit

// *** hdl/operand_decode.sv ***
// operand decode: bit addressing and the special operand classes
`timescale 1ns/1ns
// Overview of operation
// RQ1 - bit number from immediate or count_low_byte
// RQ2 - test, set, clear, invert one bit only
// RQ3 - immediate index three bits byte, four word
// RQ4 - count_low_byte high bits ignored
// RQ5 - cycle counts assume prefetched instruction bytes
// RQ6 - short branch spans -128 to +127 bytes
// RQ7 - source block through source_index_register
// RQ8 - destination block through destination_index_register
// RQ9 - translation table of 256 bytes
// RQ10 - return adds discard count to stack pointer
// RQ11 - far pointer gives offset and segment
// RQ12 - near indirect keeps program segment
// RQ13 - direct operand uses 16-bit address field
// RQ14 - register set covers eight word registers
// RQ15 - escape carries coprocessor instruction code
// RQ16 - block index steps one or two
module operand_decode (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire operand_decode_pkg::decode_req_t req_i,
  input wire logic [7:0] count_low_byte_i,
  input wire logic [15:0] pc_end_i,
  input wire logic [15:0] source_index_register_i,
  input wire logic [15:0] destination_index_register_i,
  input wire logic [15:0] stack_pointer_i,
  input wire logic [15:0] base_word_register_i,
  input wire logic [15:0] reg_file_i [operand_decode_pkg::REG_COUNT],
  output operand_decode_pkg::decode_rsp_t rsp_o,
  output logic [15:0] reg_read_o
);
  typedef struct packed {
    operand_decode_pkg::decode_rsp_t rsp;
    logic [15:0] reg_read;
  } state_t;

  state_t state_q;
  state_t state_d;
  logic [3:0] bit_index;
  logic [3:0] idx_mask;
  logic [15:0] bit_result;
  logic bit_zero;
  logic [15:0] disp_ext;
  logic [15:0] step;
  logic [15:0] blk_base;

  // the mask applies to either source, so wider immediates are truncated too
  always_comb
  begin
    idx_mask = req_i.word ? operand_decode_pkg::WORD_IDX_MASK
                          : operand_decode_pkg::BYTE_IDX_MASK; // RQ3
    if (req_i.idx_from_count)
    begin
      bit_index = count_low_byte_i[3:0] & idx_mask; // RQ1 RQ4
    end
    else
    begin
      bit_index = req_i.bit_field & idx_mask; // RQ1 RQ3
    end
  end

  bit_manip_unit u_bit (
    .value_i(req_i.value),
    .word_i(req_i.word),
    .index_i(bit_index),
    .op_i(req_i.bit_op),
    .result_o(bit_result),
    .zero_o(bit_zero)
  );

  always_comb
  begin
    disp_ext = {{8{req_i.disp8[7]}}, req_i.disp8}; // RQ6
    step = req_i.word ? operand_decode_pkg::WORD_STEP
                      : operand_decode_pkg::BYTE_STEP; // RQ16
    blk_base = req_i.blk_dst ? destination_index_register_i // RQ8
                             : source_index_register_i; // RQ7
  end

  // one registered stage: decode, address and execute resolve together,
  // relying on the instruction bytes already sitting in req_i
  always_comb
  begin
    state_d = state_q;
    state_d.rsp = '0;
    state_d.rsp.valid = req_i.valid; // RQ5
    state_d.reg_read = reg_file_i[req_i.reg_sel]; // RQ14
    if (req_i.valid)
    begin
      case (req_i.cls)
        operand_decode_pkg::OP_BIT:
        begin
          state_d.rsp.result = bit_result;
          state_d.rsp.zero = bit_zero;
          state_d.rsp.write_back =
            req_i.bit_op != operand_decode_pkg::bit_test_op; // RQ2
        end
        operand_decode_pkg::OP_SHORT_BRANCH:
        begin
          state_d.rsp.pc_next = pc_end_i + disp_ext; // RQ6
        end
        operand_decode_pkg::OP_BLOCK:
        begin
          state_d.rsp.addr = blk_base; // RQ7 RQ8
          state_d.rsp.index_reg = req_i.blk_dst ? operand_decode_pkg::REG_IY
                                                : operand_decode_pkg::REG_IX;
          state_d.rsp.index_load = 1'b1;
          if (req_i.dir_down)
          begin
            state_d.rsp.index_next = blk_base - step; // RQ16
          end
          else
          begin
            state_d.rsp.index_next = blk_base + step; // RQ16
          end
        end
        operand_decode_pkg::OP_XLAT:
        begin
          // byte index cannot leave the 256-byte table
          state_d.rsp.addr = base_word_register_i
            + {8'h00, req_i.value[7:0] & operand_decode_pkg::TABLE_LAST}; // RQ9
        end
        operand_decode_pkg::OP_RET_POP:
        begin
          // a full 16-bit count wraps the stack pointer, as the adder does
          state_d.rsp.sp_next = stack_pointer_i + req_i.imm16; // RQ10
          state_d.rsp.index_reg = operand_decode_pkg::REG_SP;
          state_d.rsp.index_load = 1'b1;
        end
        operand_decode_pkg::OP_FAR_PTR:
        begin
          state_d.rsp.pc_next = req_i.value; // RQ11
          state_d.rsp.segment = req_i.aux16; // RQ11
          state_d.rsp.seg_load = 1'b1;
        end
        operand_decode_pkg::OP_MISC:
        begin
          case (req_i.misc)
            operand_decode_pkg::MISC_NEAR_IND:
            begin
              state_d.rsp.pc_next = req_i.value; // RQ12
              state_d.rsp.seg_load = 1'b0; // RQ12
            end
            operand_decode_pkg::MISC_DIRECT:
            begin
              state_d.rsp.addr = req_i.imm16; // RQ13
            end
            operand_decode_pkg::MISC_ESCAPE:
            begin
              state_d.rsp.escape_code = req_i.imm16[7:0]; // RQ15
            end
            default:
            begin
              state_d.rsp.valid = 1'b0;
            end
          endcase
        end
        default:
        begin
          state_d.rsp.valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign rsp_o = state_q.rsp;
  assign reg_read_o = state_q.reg_read;
endmodule : operand_decode

// *** bench/operand_decode_checker.sv ***
// port assertions for the operand decode block
`timescale 1ns/1ns
module operand_decode_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire operand_decode_pkg::decode_req_t req_i,
  input wire logic [7:0] count_low_byte_i,
  input wire logic [15:0] pc_end_i,
  input wire logic [15:0] stack_pointer_i,
  input wire operand_decode_pkg::decode_rsp_t rsp_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_bit;
    req_i.valid && req_i.cls == operand_decode_pkg::OP_BIT;
  endsequence
  sequence s_blk;
    req_i.valid && req_i.cls == operand_decode_pkg::OP_BLOCK;
  endsequence
  AST_BIT_VALID: assert property (s_bit |=> rsp_o.valid)
    else $error("bit request gave no response");
  AST_IDLE: assert property (!req_i.valid |=> !rsp_o.valid)
    else $error("response without request");
  AST_SET_IMM: assert property (s_bit ##0 (req_i.word &&
    !req_i.idx_from_count && req_i.bit_op == operand_decode_pkg::bit_set_op)
    |=> rsp_o.result == ($past(req_i.value) | (16'h1 << $past(req_i.bit_field))))
    else $error("word set by immediate wrong");
  AST_CNT_INV: assert property (s_bit ##0 (!req_i.word &&
    req_i.idx_from_count && req_i.bit_op == operand_decode_pkg::bit_invert_op)
    |=> rsp_o.result == (($past(req_i.value) & 16'h00FF)
    ^ (16'h1 << $past(count_low_byte_i[2:0]))))
    else $error("byte invert by count wrong");
  AST_BRANCH: assert property (req_i.valid &&
    req_i.cls == operand_decode_pkg::OP_SHORT_BRANCH |=> rsp_o.pc_next ==
    $past(pc_end_i) + {{8{$past(req_i.disp8[7])}}, $past(req_i.disp8)})
    else $error("short branch target wrong");
  AST_SRC: assert property (s_blk ##0 !req_i.blk_dst |=>
    rsp_o.index_load && rsp_o.index_reg == operand_decode_pkg::REG_IX)
    else $error("source block not through source index");
  AST_DST: assert property (s_blk ##0 req_i.blk_dst |=>
    rsp_o.index_load && rsp_o.index_reg == operand_decode_pkg::REG_IY)
    else $error("destination block not through destination index");
  AST_RET: assert property (req_i.valid &&
    req_i.cls == operand_decode_pkg::OP_RET_POP |=>
    rsp_o.sp_next == $past(stack_pointer_i) + $past(req_i.imm16))
    else $error("return discard wrong");
endmodule : operand_decode_checker
bind operand_decode operand_decode_checker chk_u (.clk_i(clk_i),
  .rst_i(rst_i), .req_i(req_i), .count_low_byte_i(count_low_byte_i),
  .pc_end_i(pc_end_i), .stack_pointer_i(stack_pointer_i), .rsp_o(rsp_o));

// *** bench/tb_operand_decode.sv ***
// self-checking bench for the operand decode block
`timescale 1ns/1ns
module tb_operand_decode;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  operand_decode_pkg::decode_req_t req_i = '0;
  operand_decode_pkg::decode_req_t r;
  operand_decode_pkg::decode_rsp_t rsp_o;
  logic [7:0] cl_i = 8'h00;
  logic [15:0] pc_i = 16'h0000;
  logic [15:0] si_i = 16'h2000;
  logic [15:0] di_i = 16'h3000;
  logic [15:0] sp_i = 16'hFFFE;
  logic [15:0] bw_i = 16'h0100;
  logic [15:0] rf [operand_decode_pkg::REG_COUNT];
  logic [15:0] reg_read_o;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  operand_decode dut_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i),
    .count_low_byte_i(cl_i), .pc_end_i(pc_i),
    .source_index_register_i(si_i), .destination_index_register_i(di_i),
    .stack_pointer_i(sp_i), .base_word_register_i(bw_i),
    .reg_file_i(rf), .rsp_o(rsp_o), .reg_read_o(reg_read_o));
  initial
    forever #5 clk_i = ~clk_i;
  initial
    for (int k = 0; k < 8; k++)
      rf[k] = 16'h1111 * 16'(k);
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  task automatic check(input string nm, input logic [15:0] got, exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // one idle edge first, so valid never changes twice in one time step;
  // the request is held for one edge and the answer read just after valid drops
  task automatic send(input logic v);
    @(posedge clk_i);
    #1 r.valid = 1'b1;
    req_i = r;
    @(posedge clk_i);
    #1 req_i.valid = 1'b0;
    check("valid", 16'(rsp_o.valid), 16'(v));
  endtask : send
  task automatic t_bit();
    logic [15:0] m;
    logic [15:0] e;
    for (int i = 0; i < 16; i++)
    begin
      r = '0;
      r.cls = operand_decode_pkg::OP_BIT;
      r.bit_op = operand_decode_pkg::bit_op_t'(i[1:0]);
      r.word = i[2];
      r.idx_from_count = i[3];
      r.bit_field = 4'hD;
      r.value = 16'hA5F0;
      cl_i = 8'hF9;
      // index 13 masks to 5 for bytes; count 0xF9 gives 9 word, 1 byte
      case (i[3:2])
        2'h0: m = 16'h0020;
        2'h1: m = 16'h2000;
        2'h2: m = 16'h0002;
        default: m = 16'h0200;
      endcase
      e = i[2] ? r.value : (r.value & 16'h00FF);
      case (i[1:0])
        2'h1: e = e | m;
        2'h2: e = e & ~m;
        2'h3: e = e ^ m;
        default: e = e;
      endcase
      send(1'b1);
      check("bit_result", rsp_o.result, e);
      check("bit_zero", 16'(rsp_o.zero), 16'((r.value & m) == 0));
      check("bit_wb", 16'(rsp_o.write_back), 16'(i[1:0] != 0));
    end
    $display("t_bit done");
  endtask : t_bit
  task automatic t_flow();
    r = '0;
    r.cls = operand_decode_pkg::OP_SHORT_BRANCH;
    pc_i = 16'h1000;
    r.disp8 = 8'h80;
    send(1'b1);
    check("br_min", rsp_o.pc_next, 16'h0F80);
    r.disp8 = 8'h7F;
    send(1'b1);
    check("br_max", rsp_o.pc_next, 16'h107F);
    r.cls = operand_decode_pkg::OP_FAR_PTR;
    r.value = 16'h1234;
    r.aux16 = 16'h5678;
    send(1'b1);
    check("far_off", rsp_o.pc_next, 16'h1234);
    check("far_seg", rsp_o.segment, 16'h5678);
    check("far_load", 16'(rsp_o.seg_load), 16'h0001);
    r.cls = operand_decode_pkg::OP_MISC;
    r.misc = operand_decode_pkg::MISC_NEAR_IND;
    send(1'b1);
    check("near_pc", rsp_o.pc_next, 16'h1234);
    check("near_seg", 16'(rsp_o.seg_load), 16'h0000);
    r.cls = operand_decode_pkg::OP_RET_POP;
    r.imm16 = 16'h0004;
    send(1'b1);
    check("ret_sp", rsp_o.sp_next, 16'h0002);
    check("ret_reg", 16'(rsp_o.index_reg), 16'h0004);
    check("ret_load", 16'(rsp_o.index_load), 16'h0001);
    $display("t_flow done");
  endtask : t_flow
  task automatic t_addr();
    r = '0;
    r.cls = operand_decode_pkg::OP_BLOCK;
    send(1'b1);
    check("src_addr", rsp_o.addr, 16'h2000);
    check("src_step", rsp_o.index_next, 16'h2001);
    r.blk_dst = 1'b1;
    r.word = 1'b1;
    r.dir_down = 1'b1;
    send(1'b1);
    check("dst_addr", rsp_o.addr, 16'h3000);
    check("dst_step", rsp_o.index_next, 16'h2FFE);
    r = '0;
    r.cls = operand_decode_pkg::OP_XLAT;
    r.value = 16'h12FF;
    send(1'b1);
    check("xlat", rsp_o.addr, 16'h01FF);
    r.cls = operand_decode_pkg::OP_MISC;
    r.misc = operand_decode_pkg::MISC_DIRECT;
    r.imm16 = 16'hAB3C;
    r.reg_sel = 3'h6;
    send(1'b1);
    check("direct", rsp_o.addr, 16'hAB3C);
    check("regset", reg_read_o, 16'h6666);
    r.misc = operand_decode_pkg::MISC_ESCAPE;
    send(1'b1);
    check("escape", 16'(rsp_o.escape_code), 16'h003C);
    r = '0;
    send(1'b0);
    $display("t_addr done");
  endtask : t_addr
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    #1 rst_i = 1'b0;
    t_bit();
    t_flow();
    t_addr();
    end_of_test();
  end
endmodule : tb_operand_decode
